//--- bench/pecc_check_tb.sv
// Self-checking bench for the header ECC, payload and frame checksums.
// Assumes pecc_params.svh on the include path and the source model.
`timescale 1ns/10ps
`include "pecc_params.svh"

module pecc_check_tb;
  logic        clk_i, rst_n_i, hdr_valid_i, bidir_en_i, pl_valid_i;
  logic [23:0] hdr_data_i, hdr_data_o;
  logic [7:0]  hdr_ecc_i, pl_data_i, out_data_o, rd_byte_o;
  logic        hdr_valid_o, hdr_corr_o, hdr_multi_o, err_report_o;
  logic        pl_last_i, pl_ready_o, chk_en_i, out_ready_i, out_valid_o;
  logic        pl_done_o, pl_crc_err_o, px_valid_i, px_sof_i, px_eof_i;
  logic        read_transformed_frame_crc_i, rd_valid_o, err_seen;
  logic [15:0] pl_crc_o, pl_rx_crc_o, frame_crc_o, frame_rgb_crc_o;
  logic [29:0] px_comp_i;
  logic [23:0] px_rgb_i;
  logic [7:0]  got[$];
  int          n_fail, check_count, done_n, drain;

  pecc_check #(.COMP_W(10), .FIFO_DEPTH(32), .HAS_RGB_CRC(1'b0)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hdr_valid_i(hdr_valid_i),
    .hdr_data_i(hdr_data_i), .hdr_ecc_i(hdr_ecc_i),
    .bidir_en_i(bidir_en_i), .hdr_valid_o(hdr_valid_o),
    .hdr_data_o(hdr_data_o), .hdr_corr_o(hdr_corr_o),
    .hdr_multi_o(hdr_multi_o), .err_report_o(err_report_o),
    .pl_valid_i(pl_valid_i), .pl_data_i(pl_data_i),
    .pl_last_i(pl_last_i), .pl_ready_o(pl_ready_o), .chk_en_i(chk_en_i),
    .out_ready_i(out_ready_i), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .pl_done_o(pl_done_o),
    .pl_crc_err_o(pl_crc_err_o), .pl_crc_o(pl_crc_o),
    .pl_rx_crc_o(pl_rx_crc_o), .px_valid_i(px_valid_i),
    .px_sof_i(px_sof_i), .px_eof_i(px_eof_i), .px_comp_i(px_comp_i),
    .px_rgb_i(px_rgb_i),
    .read_transformed_frame_crc_i(read_transformed_frame_crc_i),
    .rd_valid_o(rd_valid_o), .rd_byte_o(rd_byte_o),
    .frame_crc_o(frame_crc_o), .frame_rgb_crc_o(frame_rgb_crc_o));

  pecc_pkt_src i_src (.clk_i(clk_i), .pl_ready_i(pl_ready_o),
    .pl_valid_o(pl_valid_i), .pl_data_o(pl_data_i),
    .pl_last_o(pl_last_i));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Drain side: held, free running, or stalling every other cycle
  always @(posedge clk_i)
    out_ready_i <= #1 (drain == 2) ? ~out_ready_i : (drain == 1);

  always @(posedge clk_i)
  begin
    if (out_valid_o === 1'b1)
      got.push_back(out_data_o);
    if (pl_done_o === 1'b1)
    begin
      done_n++;
      err_seen = pl_crc_err_o;
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chkv(input string nm, input logic [23:0] e,
                      input logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] par(input logic [23:0] d);
    return {2'h0, ^(d & 24'heffc00), ^(d & 24'hdf03f0),
            ^(d & 24'hb8e38e), ^(d & 24'h749a6d),
            ^(d & 24'hf2555b), ^(d & 24'hf12cb7)};
  endfunction

  task automatic hdr(input logic [23:0] d, input logic [7:0] ecc,
                     input logic bd, input logic [23:0] ed,
                     input logic ec, input logic em);
    hdr_valid_i = 1'b1;
    hdr_data_i  = d;
    hdr_ecc_i   = ecc;
    bidir_en_i  = bd;
    @(posedge clk_i);
    #1;
    hdr_valid_i = 1'b0;
    hdr_data_i  = ~d;
    bidir_en_i  = ~bd;
    chk1("hdr_valid_o", 1'b1, hdr_valid_o);
    chkv("hdr_data_o", ed, hdr_data_o);
    chk1("hdr_corr_o", ec, hdr_corr_o);
    chk1("hdr_multi_o", em, hdr_multi_o);
    chk1("err_report_o", em & bd, err_report_o);
    @(posedge clk_i);
    #1;
  endtask

  localparam logic [23:0] HD = 24'h5a3c96;

  task automatic t_hdr_clean();
    hdr(HD, par(HD), 1'b0, HD, 1'b0, 1'b0);
    hdr(HD, par(HD) | 8'hc0, 1'b1, HD, 1'b0, 1'b0);
  endtask

  task automatic t_hdr_single();
    for (int i = 0; i < 24; i++)
      hdr(HD ^ (24'h1 << i), par(HD), 1'b0, HD, 1'b1, 1'b0);
  endtask

  task automatic t_hdr_parity();
    for (int i = 0; i < 6; i++)
      hdr(HD, par(HD) ^ (8'h1 << i), 1'b1, HD, 1'b0, 1'b0);
  endtask

  task automatic t_hdr_multi();
    for (int i = 0; i < 23; i++)
      hdr(HD ^ (24'h3 << i), par(HD), i[0], HD ^ (24'h3 << i),
          1'b0, 1'b1);
  endtask

  task automatic pkt(input int n, input logic [7:0] seed, input bit gen,
                     input bit bad, input bit chk, input bit fill);
    logic [15:0] c;
    logic [15:0] rx;
    int          k;
    got.delete();
    done_n   = 0;
    err_seen = 1'b0;
    chk_en_i = chk;
    drain    = fill ? 0 : 2;
    fork
      i_src.send(n, seed, gen, bad);
    join_none
    if (fill)
    begin
      repeat (n + 10) @(posedge clk_i);
      #1;
      chk1("pl_ready_o full", 1'b0, pl_ready_o);
      drain = 2;
    end
    k = 0;
    while (done_n == 0 && k < 2000)
    begin
      @(posedge clk_i);
      k++;
    end
    #1;
    c = 16'hffff;
    for (int j = 0; j < n; j++)
      c = i_src.crc_byte(c, seed + 8'(j));
    rx = gen ? c : 16'h0000;
    if (bad)
      rx = rx ^ 16'h0001;
    chk1("pl_done_o", 1'b1, done_n == 1);
    chk1("pl_crc_err_o", chk && (rx != c), err_seen);
    chkv("pl_crc_o", c, pl_crc_o);
    chkv("pl_rx_crc_o", rx, pl_rx_crc_o);
    chkv("byte count", n, got.size());
    for (int j = 0; j < got.size(); j++)
      chkv("out_data_o", seed + 8'(j), got[j]);
  endtask

  task automatic frame(input logic [9:0] seed, input int np);
    logic [15:0] c;
    logic [9:0]  v;
    logic [29:0] w;
    c = 16'hffff;
    for (int p = 0; p < np; p++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        v = seed + 10'(p * 3 + j) * 10'd97;
        w[j*10+:10] = v;
        c = i_src.crc_byte(c, v[9:2]);
      end
      px_valid_i = 1'b1;
      px_sof_i   = (p == 0);
      px_eof_i   = (p == np - 1);
      px_comp_i  = w;
      px_rgb_i   = ~w[23:0];
      @(posedge clk_i);
      #1;
    end
    px_valid_i = 1'b0;
    px_sof_i   = 1'b0;
    px_eof_i   = 1'b0;
    px_comp_i  = ~px_comp_i;
    @(posedge clk_i);
    #1;
    chkv("frame_crc_o", c, frame_crc_o);
    chkv("frame_rgb_crc_o", 16'hffff, frame_rgb_crc_o);
    read_transformed_frame_crc_i = 1'b1;
    @(posedge clk_i);
    #1;
    read_transformed_frame_crc_i = 1'b0;
    chk1("rd_valid_o low", 1'b1, rd_valid_o);
    chkv("rd_byte_o low", c[7:0], rd_byte_o);
    @(posedge clk_i);
    #1;
    chk1("rd_valid_o high", 1'b1, rd_valid_o);
    chkv("rd_byte_o high", c[15:8], rd_byte_o);
    @(posedge clk_i);
    #1;
    chk1("rd_valid_o idle", 1'b0, rd_valid_o);
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    {hdr_valid_i, bidir_en_i, chk_en_i, out_ready_i} = 4'h0;
    {px_valid_i, px_sof_i, px_eof_i} = 3'h0;
    read_transformed_frame_crc_i = 1'b0;
    hdr_data_i = 24'h000000;
    hdr_ecc_i  = 8'h00;
    px_comp_i  = 30'h0;
    px_rgb_i   = 24'h000000;
    {n_fail, check_count, done_n, drain} = 0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk1("pl_ready_o reset", 1'b1, pl_ready_o);
    t_hdr_clean();
    t_hdr_single();
    t_hdr_parity();
    t_hdr_multi();
    pkt(0, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
    pkt(9, 8'h31, 1'b1, 1'b0, 1'b1, 1'b0);
    chkv("check value", 16'h6f91, pl_crc_o);
    pkt(5, 8'ha0, 1'b1, 1'b1, 1'b1, 1'b0);
    pkt(5, 8'ha0, 1'b1, 1'b1, 1'b0, 1'b0);
    pkt(6, 8'h10, 1'b0, 1'b0, 1'b0, 1'b0);
    pkt(40, 8'h80, 1'b1, 1'b0, 1'b1, 1'b1);
    frame(10'h155, 3);
    frame(10'h0f3, 2);
    finish_test();
  end

  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end
endmodule // pecc_check_tb

//--- bench/pecc_pkt_src.sv
// Behavioural packet source: payload bytes, then a two-byte checksum.
// Assumes it is driven from the bench, one byte per ready handshake.
`timescale 1ns/10ps

module pecc_pkt_src (
  input  wire logic       clk_i,
  input  wire logic       pl_ready_i,
  output logic            pl_valid_o,
  output logic      [7:0] pl_data_o,
  output logic            pl_last_o
);
  initial
  begin
    pl_valid_o = 1'b0;
    pl_data_o  = 8'h00;
    pl_last_o  = 1'b0;
  end

  // Reflected step, low bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic fb;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ b[i];
      c  = c >> 1;
      if (fb)
        c = c ^ 16'h8408;
    end
    return c;
  endfunction

  // Hold each byte until the ready edge, then move on
  task automatic put(input logic [7:0] b, input logic l);
    pl_valid_o = 1'b1;
    pl_data_o  = b;
    pl_last_o  = l;
    @(posedge clk_i);
    while (pl_ready_i !== 1'b1)
      @(posedge clk_i);
    #1;
  endtask

  // Caller starts just after a rising edge
  task automatic send(input int n, input logic [7:0] seed,
                      input bit gen, input bit bad);
    logic [15:0] c;
    c = 16'hffff;
    for (int k = 0; k < n; k++)
    begin
      put(seed + 8'(k), 1'b0);
      c = crc_byte(c, seed + 8'(k));
    end
    if (!gen)
      c = 16'h0000;
    if (bad)
      c = c ^ 16'h0001;
    put(c[7:0], 1'b0);
    put(c[15:8], 1'b1);
    pl_valid_o = 1'b0;
    pl_last_o  = 1'b0;
    pl_data_o  = ~pl_data_o;
  endtask
endmodule // pecc_pkt_src

//--- common/pecc_params.svh
// Constants for the packet ECC and checksum checker.
// Included by name; defines only, no logic.
`ifndef PECC_PARAMS_SVH
`define PECC_PARAMS_SVH

`define PECC_HDR_W      24
`define PECC_SYN_W      6
`define PECC_ECC_W      8
`define PECC_CRC_W      16
`define PECC_BYTE_W     8
`define PECC_CRC_PRESET 16'hffff
`define PECC_CRC_POLY   16'h8408
`define PECC_FIFO_DEPTH 32
`define PECC_HOLD_NONE  2'h0
`define PECC_HOLD_ONE   2'h1
`define PECC_HOLD_TWO   2'h2

`endif

//--- common/pecc_pkg.sv
// Types for the packet ECC and checksum checker.
// Assumes pecc_params.svh is on the include path.
package pecc_pkg;

  typedef enum logic [2:0] {
    RD_IDLE = 3'h1,
    RD_LOW  = 3'h2,
    RD_HIGH = 3'h4
  } pecc_rd_state_t;

  typedef logic [5:0] pecc_syn_t;

endpackage

//--- hdl/pecc_check.sv
// Packet header ECC correction, payload checksum check and frame CRC.
// Assumes one clock; all inputs come from logic on clk_i.
`timescale 1ns/10ps
`include "pecc_params.svh"

module pecc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = `PECC_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  wr_ready_o,
  output logic                  rd_valid_o,
  output logic      [WIDTH-1:0] rd_data_o,
  input  wire logic             rd_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;
  logic             ready_q;
  logic             empty_q;

  assign push       = wr_valid_i && ready_q;
  assign pop        = rd_ready_i && !empty_q;
  assign cnt_d      = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign wr_ready_o = ready_q;
  assign rd_valid_o = !empty_q;
  assign rd_data_o  = mem_q[rd_ptr_q];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      ready_q  <= 1'b1;
      empty_q  <= 1'b1;
    end
    else
    begin
      wr_ptr_q <= push ? AW'((wr_ptr_q + 1'b1) % DEPTH) : wr_ptr_q;
      rd_ptr_q <= pop ? AW'((rd_ptr_q + 1'b1) % DEPTH) : rd_ptr_q;
      cnt_q    <= cnt_d;
      ready_q  <= (cnt_d != (AW+1)'(DEPTH));
      empty_q  <= (cnt_d == '0);
    end
  end
endmodule // pecc_fifo

module pecc_check #(
  parameter int unsigned COMP_W      = 10,
  parameter int unsigned FIFO_DEPTH  = `PECC_FIFO_DEPTH,
  parameter bit          HAS_RGB_CRC = 1'b0
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  hdr_valid_i,
  input  wire logic [`PECC_HDR_W-1:0] hdr_data_i,
  input  wire logic [`PECC_ECC_W-1:0] hdr_ecc_i,
  input  wire logic                  bidir_en_i,
  output logic                       hdr_valid_o,
  output logic      [`PECC_HDR_W-1:0] hdr_data_o,
  output logic                       hdr_corr_o,
  output logic                       hdr_multi_o,
  output logic                       err_report_o,
  input  wire logic                  pl_valid_i,
  input  wire logic [`PECC_BYTE_W-1:0] pl_data_i,
  input  wire logic                  pl_last_i,
  output logic                       pl_ready_o,
  input  wire logic                  chk_en_i,
  input  wire logic                  out_ready_i,
  output logic                       out_valid_o,
  output logic      [`PECC_BYTE_W-1:0] out_data_o,
  output logic                       pl_done_o,
  output logic                       pl_crc_err_o,
  output logic      [`PECC_CRC_W-1:0] pl_crc_o,
  output logic      [`PECC_CRC_W-1:0] pl_rx_crc_o,
  input  wire logic                  px_valid_i,
  input  wire logic                  px_sof_i,
  input  wire logic                  px_eof_i,
  input  wire logic [3*COMP_W-1:0]   px_comp_i,
  input  wire logic [3*`PECC_BYTE_W-1:0] px_rgb_i,
  input  wire logic                  read_transformed_frame_crc_i,
  output logic                       rd_valid_o,
  output logic      [`PECC_BYTE_W-1:0] rd_byte_o,
  output logic      [`PECC_CRC_W-1:0] frame_crc_o,
  output logic      [`PECC_CRC_W-1:0] frame_rgb_crc_o
);
  localparam int unsigned BW = `PECC_BYTE_W;

  // Parity over the 24 header bits; top two ECC bits unused
  function automatic pecc_pkg::pecc_syn_t ecc_par(
    input logic [`PECC_HDR_W-1:0] d);
    pecc_pkg::pecc_syn_t p;
    p[0] = d[0]^d[1]^d[2]^d[4]^d[5]^d[7]^d[10]^d[11]^d[13]^d[16]
         ^ d[20]^d[21]^d[22]^d[23];
    p[1] = d[0]^d[1]^d[3]^d[4]^d[6]^d[8]^d[10]^d[12]^d[14]^d[17]
         ^ d[20]^d[21]^d[22]^d[23];
    p[2] = d[0]^d[2]^d[3]^d[5]^d[6]^d[9]^d[11]^d[12]^d[15]^d[18]
         ^ d[20]^d[21]^d[22];
    p[3] = d[1]^d[2]^d[3]^d[7]^d[8]^d[9]^d[13]^d[14]^d[15]^d[19]
         ^ d[20]^d[21]^d[23];
    p[4] = d[4]^d[5]^d[6]^d[7]^d[8]^d[9]^d[16]^d[17]^d[18]^d[19]
         ^ d[20]^d[22]^d[23];
    p[5] = d[10]^d[11]^d[12]^d[13]^d[14]^d[15]^d[16]^d[17]^d[18]
         ^ d[19]^d[21]^d[22]^d[23];
    return p;
  endfunction

  // Bit i of the mask is set when s is the syndrome of data bit i
  function automatic logic [`PECC_HDR_W-1:0] flip_mask(
    input pecc_pkg::pecc_syn_t s);
    logic [`PECC_HDR_W-1:0] m;
    m = '0;
    for (int i = 0; i < `PECC_HDR_W; i++)
    begin
      m[i] = (s == ecc_par(`PECC_HDR_W'(1) << i));
    end
    return m;
  endfunction

  // One byte through the reflected CRC register, LSB first
  function automatic logic [`PECC_CRC_W-1:0] crc_byte(
    input logic [`PECC_CRC_W-1:0] c,
    input logic [BW-1:0]          b);
    logic [`PECC_CRC_W-1:0] r;
    r = c;
    for (int i = 0; i < BW; i++)
    begin
      if (r[0] ^ b[i])
        r = (r >> 1) ^ `PECC_CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Header check
  pecc_pkg::pecc_syn_t    syn;
  logic [`PECC_HDR_W-1:0] mask;
  logic                   bit_hit;
  logic                   par_hit;
  logic                   multi;

  assign syn     = hdr_ecc_i[`PECC_SYN_W-1:0] ^ ecc_par(hdr_data_i);
  assign mask    = flip_mask(syn);
  assign bit_hit = |mask;
  assign par_hit = (syn != '0) && ((syn & (syn - 1'b1)) == '0);
  assign multi   = (syn != '0) && !bit_hit && !par_hit;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdr_valid_o  <= 1'b0;
      hdr_data_o   <= '0;
      hdr_corr_o   <= 1'b0;
      hdr_multi_o  <= 1'b0;
      err_report_o <= 1'b0;
    end
    else
    begin
      hdr_valid_o  <= hdr_valid_i;
      hdr_data_o   <= hdr_valid_i ? hdr_data_i ^ mask : hdr_data_o;
      hdr_corr_o   <= hdr_valid_i && bit_hit;
      hdr_multi_o  <= hdr_valid_i && multi;
      err_report_o <= hdr_valid_i && multi && bidir_en_i;
    end
  end

  // Payload path: the last two bytes of each packet are the checksum
  logic          f_valid;
  logic [BW:0]   f_word;
  logic          pop;
  logic          f_last;
  logic [BW-1:0] f_byte;
  logic [1:0]    hold_q;
  logic [BW-1:0] b0_q;
  logic [BW-1:0] b1_q;
  logic [`PECC_CRC_W-1:0] crc_q;
  logic [`PECC_CRC_W-1:0] crc_adv;
  logic [`PECC_CRC_W-1:0] crc_fin;
  logic [`PECC_CRC_W-1:0] rx_sum;
  logic          full_hold;

  pecc_fifo #(
    .WIDTH (BW + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .wr_valid_i (pl_valid_i),
    .wr_data_i  ({pl_last_i, pl_data_i}),
    .wr_ready_o (pl_ready_o),
    .rd_valid_o (f_valid),
    .rd_data_o  (f_word),
    .rd_ready_i (out_ready_i)
  );

  assign pop       = f_valid && out_ready_i;
  assign f_last    = f_word[BW];
  assign f_byte    = f_word[BW-1:0];
  assign full_hold = (hold_q == `PECC_HOLD_TWO);
  assign crc_adv   = crc_byte(crc_q, b0_q);
  assign crc_fin   = full_hold ? crc_adv : crc_q;
  assign rx_sum    = {f_byte, full_hold ? b1_q : b0_q};

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q       <= `PECC_HOLD_NONE;
      b0_q         <= '0;
      b1_q         <= '0;
      crc_q        <= `PECC_CRC_PRESET;
      out_valid_o  <= 1'b0;
      out_data_o   <= '0;
      pl_done_o    <= 1'b0;
      pl_crc_err_o <= 1'b0;
      pl_crc_o     <= `PECC_CRC_PRESET;
      pl_rx_crc_o  <= `PECC_CRC_PRESET;
    end
    else
    begin
      out_valid_o  <= pop && full_hold;
      out_data_o   <= b0_q;
      pl_done_o    <= pop && f_last;
      pl_crc_err_o <= pop && f_last && chk_en_i && (crc_fin != rx_sum);
      if (pop && f_last)
      begin
        crc_q       <= `PECC_CRC_PRESET;
        hold_q      <= `PECC_HOLD_NONE;
        pl_crc_o    <= crc_fin;
        pl_rx_crc_o <= rx_sum;
      end
      else if (pop)
      begin
        case (hold_q)
          `PECC_HOLD_NONE:
          begin
            b0_q   <= f_byte;
            hold_q <= `PECC_HOLD_ONE;
          end
          `PECC_HOLD_ONE:
          begin
            b1_q   <= f_byte;
            hold_q <= `PECC_HOLD_TWO;
          end
          default:
          begin
            crc_q <= crc_adv;
            b0_q  <= b1_q;
            b1_q  <= f_byte;
          end
        endcase
      end
    end
  end

  // Frame checksums, component 0 first
  logic [`PECC_CRC_W-1:0] fr_acc_q;
  logic [`PECC_CRC_W-1:0] rgb_acc_q;
  logic [`PECC_CRC_W-1:0] fr_base;
  logic [`PECC_CRC_W-1:0] rgb_base;
  logic [`PECC_CRC_W-1:0] fr_next;
  logic [`PECC_CRC_W-1:0] rgb_next;

  assign fr_base  = px_sof_i ? `PECC_CRC_PRESET : fr_acc_q;
  assign rgb_base = px_sof_i ? `PECC_CRC_PRESET : rgb_acc_q;
  assign fr_next  = crc_byte(crc_byte(crc_byte(fr_base,
                      px_comp_i[COMP_W-1 -: BW]),
                      px_comp_i[2*COMP_W-1 -: BW]),
                      px_comp_i[3*COMP_W-1 -: BW]);
  assign rgb_next = crc_byte(crc_byte(crc_byte(rgb_base,
                      px_rgb_i[BW-1:0]), px_rgb_i[2*BW-1:BW]),
                      px_rgb_i[3*BW-1:2*BW]);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fr_acc_q        <= `PECC_CRC_PRESET;
      rgb_acc_q       <= `PECC_CRC_PRESET;
      frame_crc_o     <= `PECC_CRC_PRESET;
      frame_rgb_crc_o <= `PECC_CRC_PRESET;
    end
    else if (px_valid_i)
    begin
      fr_acc_q <= fr_next;
      frame_crc_o <= px_eof_i ? fr_next : frame_crc_o;
      if (HAS_RGB_CRC)
      begin
        rgb_acc_q       <= rgb_next;
        frame_rgb_crc_o <= px_eof_i ? rgb_next : frame_rgb_crc_o;
      end
    end
  end

  // Read-back: low byte then high byte
  pecc_pkg::pecc_rd_state_t rd_state_q;
  logic [`PECC_CRC_W-1:0]   rd_snap_q;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_state_q <= pecc_pkg::RD_IDLE;
      rd_snap_q  <= '0;
      rd_valid_o <= 1'b0;
      rd_byte_o  <= '0;
    end
    else
    begin
      case (rd_state_q)
        pecc_pkg::RD_IDLE:
        begin
          rd_valid_o <= read_transformed_frame_crc_i;
          rd_byte_o  <= frame_crc_o[BW-1:0];
          rd_snap_q  <= frame_crc_o;
          if (read_transformed_frame_crc_i)
            rd_state_q <= pecc_pkg::RD_LOW;
        end
        pecc_pkg::RD_LOW:
        begin
          rd_valid_o <= 1'b1;
          rd_byte_o  <= rd_snap_q[`PECC_CRC_W-1:BW];
          rd_state_q <= pecc_pkg::RD_HIGH;
        end
        default:
        begin
          rd_valid_o <= 1'b0;
          rd_state_q <= pecc_pkg::RD_IDLE;
        end
      endcase
    end
  end

  property p_clean;
    @(posedge clk_i) disable iff (!rst_n)
    hdr_valid_i && (syn == '0) |=> hdr_valid_o &&
      (hdr_data_o == $past(hdr_data_i)) && !hdr_corr_o && !hdr_multi_o;
  endproperty
  a_clean: assert property (p_clean) else $error("clean header altered");

  property p_single;
    @(posedge clk_i) disable iff (!rst_n)
    hdr_valid_i && bit_hit |=> hdr_corr_o && !hdr_multi_o &&
      ($countones(hdr_data_o ^ $past(hdr_data_i)) == 1);
  endproperty
  a_single: assert property (p_single) else $error("bad correction");

  property p_parity;
    @(posedge clk_i) disable iff (!rst_n)
    hdr_valid_i && par_hit |=> (hdr_data_o == $past(hdr_data_i)) &&
      !hdr_corr_o && !hdr_multi_o;
  endproperty
  a_parity: assert property (p_parity) else $error("parity err misread");

  property p_multi;
    @(posedge clk_i) disable iff (!rst_n)
    hdr_multi_o |-> $past(hdr_valid_i) && ($past(syn) != '0) &&
      !$past(bit_hit) && !$past(par_hit) && !hdr_corr_o;
  endproperty
  a_multi: assert property (p_multi) else $error("multi flag wrong");

  property p_report;
    @(posedge clk_i) disable iff (!rst_n)
    err_report_o == (hdr_multi_o && $past(bidir_en_i));
  endproperty
  a_report: assert property (p_report) else $error("report gating wrong");

  property p_compare;
    @(posedge clk_i) disable iff (!rst_n)
    pl_done_o |-> pl_crc_err_o ==
      ($past(chk_en_i) && (pl_crc_o != pl_rx_crc_o));
  endproperty
  a_compare: assert property (p_compare) else $error("crc compare wrong");

  property p_preset;
    @(posedge clk_i) disable iff (!rst_n)
    pl_done_o |-> (crc_q == `PECC_CRC_PRESET) && (hold_q == '0);
  endproperty
  a_preset: assert property (p_preset) else $error("crc not preset");

  property p_read;
    @(posedge clk_i) disable iff (!rst_n)
    read_transformed_frame_crc_i && (rd_state_q == pecc_pkg::RD_IDLE)
      |=> rd_valid_o && (rd_byte_o == $past(frame_crc_o[BW-1:0]))
      ##1 rd_valid_o && (rd_byte_o == $past(frame_crc_o[`PECC_CRC_W-1:BW], 2))
      ##1 !rd_valid_o;
  endproperty
  a_read: assert property (p_read) else $error("read-back order wrong");

  property p_frame_hold;
    @(posedge clk_i) disable iff (!rst_n)
    !(px_valid_i && px_eof_i) |=> $stable(frame_crc_o);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame crc moved");

  c_corr: cover property (@(posedge clk_i) disable iff (!rst_n) hdr_corr_o);
  c_multi: cover property (@(posedge clk_i) disable iff (!rst_n)
    err_report_o);
  c_crc_err: cover property (@(posedge clk_i) disable iff (!rst_n)
    pl_crc_err_o);
  c_full: cover property (@(posedge clk_i) disable iff (!rst_n)
    !pl_ready_o);
  c_read: cover property (@(posedge clk_i) disable iff (!rst_n)
    rd_state_q == pecc_pkg::RD_HIGH);
endmodule // pecc_check
